/* lp_pd_pkg.sv */
package lp_pd_pkg;

  // pins seen from the controller side, sampled by mclk_i
  typedef struct packed {
    logic ck;
    logic cke;
    logic cs_n;
    logic [9:0] ca;
    logic zq_tied;
    logic reinit_done;
  } link_pins_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PD,
    ST_DPD
  } pwr_state_e;

  // rising-edge CA codes, ca[0] is CA0
  localparam logic [2:0] CA_NOP = 3'h7;
  localparam logic [2:0] CA_DPD = 3'h3;
  localparam logic [3:0] CA_MRW = 4'h0;
  localparam logic [2:0] CA_REF = 3'h4;
  localparam logic [1:0] CA_ACT = 2'h2;
  localparam logic [3:0] CA_PRE = 4'hB;
  localparam logic [5:0] MA_ZQ = 6'h0A;

  // internal completion time of row and refresh work, in CK cycles
  localparam logic [3:0] OP_BUSY_CK = 4'h4;

  localparam logic RST_CKE = 1'b1;
  localparam logic RST_ARRAY_LOST = 1'b0;

endpackage

/* lp_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module lp_pin_sync (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire lp_pd_pkg::link_pins_s pins_i,
  output lp_pd_pkg::link_pins_s pins_o,
  output logic ck_rise_o
);
  import lp_pd_pkg::*;

  link_pins_s meta;
  link_pins_s stable;
  logic ck_last;
  logic next_ck_last;

  always_comb begin
    next_ck_last = stable.ck;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      stable <= '0;
      ck_last <= 1'b0;
    end else begin
      meta <= pins_i;
      stable <= meta;
      ck_last <= next_ck_last;
    end
  end

  assign pins_o = stable;
  assign ck_rise_o = stable.ck & ~ck_last;

endmodule

`default_nettype wire

/* lp_power_ctrl.sv */
// Operation
// - ZQ strapped to supply ignores calibration commands
// - CKE low with CS# high enters power-down
// - row work finishes before low-power level
// - power-down disables buffers except clock, CKE
// - no refresh performed while in power-down
// - CKE sampled high leaves power-down
// - CKE low with DPD code enters deep power-down
// - deep power-down loses array, cuts buffers, power
// - NOP is CS# high or CA0-2 high
`timescale 1ns/1ps
`default_nettype none

module lp_power_ctrl (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire lp_pd_pkg::link_pins_s pins_i,
  output logic pd_o,
  output logic dpd_o,
  output logic inbuf_en_o,
  output logic outbuf_en_o,
  output logic core_power_en_o,
  output logic refresh_en_o,
  output logic pd_low_power_o,
  output logic array_lost_o,
  output logic zq_cal_start_o,
  output logic nop_o
);
  import lp_pd_pkg::*;

  link_pins_s pin;
  logic ck_rise;

  lp_pin_sync u_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .pins_i(pins_i),
    .pins_o(pin),
    .ck_rise_o(ck_rise)
  );

  pwr_state_e state;
  pwr_state_e next_state;
  logic cke_q;
  logic next_cke_q;
  logic [3:0] op_cnt;
  logic [3:0] next_op_cnt;
  logic array_lost;
  logic next_array_lost;
  logic zq_start;
  logic next_zq_start;
  logic nop;
  logic next_nop;

  logic is_nop;
  logic cmd_live;
  logic pd_enter;
  logic dpd_enter;

  always_comb begin
    is_nop = pin.cs_n | (pin.ca[2:0] == CA_NOP);
    cmd_live = cke_q & pin.cke & ~is_nop;
    pd_enter = cke_q & ~pin.cke & pin.cs_n;
    dpd_enter = cke_q & ~pin.cke & ~pin.cs_n
      & (pin.ca[2:0] == CA_DPD);
  end

  always_comb begin
    next_state = state;
    next_cke_q = cke_q;
    next_op_cnt = op_cnt;
    next_array_lost = array_lost;
    next_zq_start = 1'b0;
    next_nop = 1'b0;
    if (ck_rise) begin
      next_cke_q = pin.cke;
      // row and refresh work keeps running across power-down entry
      if (op_cnt != 4'h0) begin
        next_op_cnt = op_cnt - 4'h1;
      end
      case (state)
        ST_IDLE: begin
          if (dpd_enter) begin
            next_state = ST_DPD;
            next_array_lost = 1'b1;
            next_op_cnt = 4'h0;
          end else if (pd_enter) begin
            next_state = ST_PD;
          end else if (cke_q & pin.cke & is_nop) begin
            next_nop = 1'b1;
          end else if (cmd_live) begin
            if (pin.ca[3:0] == CA_MRW && pin.ca[9:4] == MA_ZQ) begin
              next_zq_start = ~pin.zq_tied;
            end
            if (pin.ca[2:0] == CA_REF || pin.ca[1:0] == CA_ACT
                || pin.ca[3:0] == CA_PRE) begin
              next_op_cnt = OP_BUSY_CK;
            end
          end
        end
        ST_PD: begin
          if (pin.cke) begin
            next_state = ST_IDLE;
          end
        end
        ST_DPD: begin
          // only CKE and the finished reinitialization matter here
          if (pin.cke & pin.reinit_done) begin
            next_state = ST_IDLE;
            next_array_lost = 1'b0;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      cke_q <= RST_CKE;
      op_cnt <= 4'h0;
      array_lost <= RST_ARRAY_LOST;
      zq_start <= 1'b0;
      nop <= 1'b0;
    end else begin
      state <= next_state;
      cke_q <= next_cke_q;
      op_cnt <= next_op_cnt;
      array_lost <= next_array_lost;
      zq_start <= next_zq_start;
      nop <= next_nop;
    end
  end

  assign pd_o = (state == ST_PD);
  assign dpd_o = (state == ST_DPD);
  assign inbuf_en_o = (state == ST_IDLE);
  assign outbuf_en_o = (state == ST_IDLE);
  assign core_power_en_o = (state != ST_DPD);
  assign refresh_en_o = (state == ST_IDLE);
  assign pd_low_power_o = (state == ST_PD) && (op_cnt == 4'h0);
  assign array_lost_o = array_lost;
  assign zq_cal_start_o = zq_start;
  assign nop_o = nop;

  sequence s_pd_edge;
    ck_rise && state == ST_IDLE && cke_q && !pin.cke && pin.cs_n;
  endsequence

  sequence s_dpd_edge;
    ck_rise && state == ST_IDLE && cke_q && !pin.cke && !pin.cs_n
      && pin.ca[2:0] == 3'h3;
  endsequence

  property p_zq_ignored;
    @(posedge mclk_i) disable iff (!rstn_i)
    $past(pin.zq_tied) |-> !zq_cal_start_o;
  endproperty
  a_zq_ignored: assert property (p_zq_ignored)
    else $error("zq calibration started with zq strapped");

  property p_pd_entry;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_pd_edge |=> pd_o && !inbuf_en_o ##1 pd_o;
  endproperty
  a_pd_entry: assert property (p_pd_entry)
    else $error("power-down not entered on cke low");

  property p_low_power;
    @(posedge mclk_i) disable iff (!rstn_i)
    pd_o && op_cnt != 4'h0 |-> !pd_low_power_o;
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("low-power level before row work done");

  property p_row_busy;
    @(posedge mclk_i) disable iff (!rstn_i)
    ck_rise && state == ST_IDLE && cmd_live && pin.ca[1:0] == CA_ACT
      |=> op_cnt == OP_BUSY_CK;
  endproperty
  a_row_busy: assert property (p_row_busy)
    else $error("row work not counted after activate");

  property p_buffers;
    @(posedge mclk_i) disable iff (!rstn_i)
    (pd_o || dpd_o) |-> !inbuf_en_o && !outbuf_en_o;
  endproperty
  a_buffers: assert property (p_buffers)
    else $error("buffers enabled in power-down");

  property p_no_refresh;
    @(posedge mclk_i) disable iff (!rstn_i)
    $rose(pd_o) |-> !refresh_en_o throughout (pd_o [*2]);
  endproperty
  a_no_refresh: assert property (p_no_refresh)
    else $error("refresh enabled in power-down");

  property p_pd_exit;
    @(posedge mclk_i) disable iff (!rstn_i)
    ck_rise && pd_o && pin.cke |=> !pd_o && inbuf_en_o;
  endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("power-down not left on cke high");

  property p_dpd_entry;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_dpd_edge |=> dpd_o && array_lost_o && !core_power_en_o;
  endproperty
  a_dpd_entry: assert property (p_dpd_entry)
    else $error("deep power-down not entered");

  property p_nop;
    @(posedge mclk_i) disable iff (!rstn_i)
    ck_rise && state == ST_IDLE && cke_q && pin.cke && pin.cs_n
      |=> nop_o ##1 !nop_o;
  endproperty
  a_nop: assert property (p_nop)
    else $error("nop not recognised");

  property p_dpd_ignore;
    @(posedge mclk_i) disable iff (!rstn_i)
    dpd_o && !(ck_rise && pin.cke && pin.reinit_done)
      |=> dpd_o && !zq_cal_start_o && !nop_o;
  endproperty
  a_dpd_ignore: assert property (p_dpd_ignore)
    else $error("command acted on in deep power-down");

endmodule

`default_nettype wire

/* lp_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none

module lp_ctrl_model (
  input wire logic mclk_i,
  output var lp_pd_pkg::link_pins_s pins_o
);
  import lp_pd_pkg::*;

  initial pins_o = '{1'b0, 1'b1, 1'b1, 10'h000, 1'b0, 1'b0};

  // one 16 mclk CK period, pins set 7 mclk ahead of the rise
  task automatic frame(input logic cke, input logic cs_n,
                       input logic [9:0] ca);
    @(posedge mclk_i);
    pins_o.cke <= cke;
    pins_o.cs_n <= cs_n;
    // deselected CA is meaningless: show a changing pattern
    pins_o.ca <= cs_n ? ~pins_o.ca : ca;
    repeat (7) @(posedge mclk_i);
    pins_o.ck <= 1'b1;
    repeat (8) @(posedge mclk_i);
    pins_o.ck <= 1'b0; // clock rests low between frames
  endtask

  task automatic straps(input logic zq, input logic ri);
    @(posedge mclk_i);
    pins_o.zq_tied <= zq;
    pins_o.reinit_done <= ri;
  endtask
endmodule

`default_nettype wire

/* lp_power_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module lp_power_ctrl_tb;
  import lp_pd_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  link_pins_s pins;
  logic pd_o, dpd_o, inb, outb, core, refr, lowp, lost, zq_o, nop_o;
  int fail_count = 0;
  int cmp_count = 0;
  int nops = 0;
  int zqs = 0;

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    if (nop_o === 1'b1)
      nops <= nops + 1;
    if (zq_o === 1'b1)
      zqs <= zqs + 1;
  end

  lp_ctrl_model lp_ctrl_model_i (.mclk_i(mclk_i), .pins_o(pins));

  lp_power_ctrl lp_power_ctrl_i (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .pins_i(pins), .pd_o(pd_o),
    .dpd_o(dpd_o), .inbuf_en_o(inb), .outbuf_en_o(outb),
    .core_power_en_o(core), .refresh_en_o(refr), .pd_low_power_o(lowp),
    .array_lost_o(lost), .zq_cal_start_o(zq_o), .nop_o(nop_o)
  );

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s exp %0h seen %0h", what, exp, seen);
    end
  endtask

  // pd, dpd, inbuf, outbuf, core power, refresh
  task automatic outs(input logic [5:0] exp);
    check("state outputs", {pd_o, dpd_o, inb, outb, core, refr}, exp);
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_nop();
    int n;
    n = nops;
    lp_ctrl_model_i.frame(1'b1, 1'b1, 10'h000);
    lp_ctrl_model_i.frame(1'b1, 1'b0, 10'h007);
    lp_ctrl_model_i.frame(1'b1, 1'b0, 10'h003);
    check("nop count", nops - n, 2);
  endtask

  task automatic t_zq();
    lp_ctrl_model_i.straps(1'b0, 1'b0);
    lp_ctrl_model_i.frame(1'b1, 1'b0, {6'h0B, 4'h0});
    lp_ctrl_model_i.frame(1'b1, 1'b0, 10'h007);
    check("zq other mr", zqs, 0);
    lp_ctrl_model_i.frame(1'b1, 1'b0, {6'h0A, 4'h0});
    // calibration running: only nops, cke kept high
    repeat (2) lp_ctrl_model_i.frame(1'b1, 1'b0, 10'h007);
    check("zq starts", zqs, 1);
    lp_ctrl_model_i.straps(1'b1, 1'b0);
    lp_ctrl_model_i.frame(1'b1, 1'b0, {6'h0A, 4'h0});
    lp_ctrl_model_i.frame(1'b1, 1'b0, 10'h007);
    check("zq tied", zqs, 1);
  endtask

  task automatic t_pd();
    int n;
    // no read, write or mode read precedes cke low
    lp_ctrl_model_i.frame(1'b1, 1'b0, 10'h002);
    lp_ctrl_model_i.frame(1'b0, 1'b1, 10'h000);
    outs(6'h22);
    check("low power early", lowp, 0);
    n = nops;
    // nop right after entry, then cke kept low
    repeat (5) lp_ctrl_model_i.frame(1'b0, 1'b0, 10'h007);
    check("low power", lowp, 1);
    check("nop in pd", nops - n, 0);
    lp_ctrl_model_i.frame(1'b1, 1'b1, 10'h000);
    outs(6'h0F);
    // cke held high and exit latency kept before the next command
    lp_ctrl_model_i.frame(1'b1, 1'b1, 10'h000);
  endtask

  task automatic t_dpd();
    lp_ctrl_model_i.frame(1'b0, 1'b0, 10'h003);
    outs(6'h10);
    check("array lost", lost, 1);
    lp_ctrl_model_i.frame(1'b0, 1'b0, 10'h007);
    lp_ctrl_model_i.straps(1'b0, 1'b0);
    lp_ctrl_model_i.frame(1'b1, 1'b0, {6'h0A, 4'h0});
    outs(6'h10);
    check("zq in deep", zqs, 1);
    lp_ctrl_model_i.straps(1'b0, 1'b1);
    lp_ctrl_model_i.frame(1'b1, 1'b1, 10'h000);
    outs(6'h0F);
    check("array kept", lost, 0);
  endtask

  initial begin
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    outs(6'h0F);
    t_nop();
    t_zq();
    t_pd();
    t_dpd();
    give_verdict();
  end

  initial begin
    repeat (6000) @(posedge mclk_i);
    fail_count++;
    give_verdict();
  end
endmodule

`default_nettype wire
